// ### hdl/nvsram_host_ctrl.sv
// Notes on behaviour
// R1 - prefix reads 0000,1555,0AAA,1FFF,10F0 in order
// R2 - sixth read 0F0F starts store
// R3 - sixth read 0F0E starts recall
// R4 - write strobe stays high during command
// R5 - other access between steps aborts sequence
// R6 - output gate irrelevant to command sequence
// R7 - each step is its own chip-select pulse
// R8 - short minimum-width pulse still counts
// R9 - repeated same-address pulses break sequence
// R10 - device busy, host sends nothing meanwhile
// R11 - no ordinary access during nonvolatile cycle
// R12 - store erases then programs, inside device
// R13 - store done after at most 10 ms
// R14 - recall clears then copies, repeatable
// R15 - power-up recall, wait 20 us first
// R16 - low supply stops store, not recall
// R17 - hold write strobe high through power-up
// R18 - read: select and gate low, write high
// R19 - continuous read follows address changes
// R20 - write: select and write low, address stable
// R21 - gate high during writes
// R22 - broken sequence restarts at 0000
module nvsram_host_ctrl
  import nvsram_host_pkg::*;
#(
  parameter int STORE_WAIT  = STORE_CYC,
  parameter int RECALL_WAIT = RECALL_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // user request port
  input  wire logic              req_valid_i,
  input  wire logic [1:0]        req_op_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic                   nv_busy_o,
  // supply indications
  input  wire logic              power_good_i,
  input  wire logic              low_supply_i,
  // memory pins
  output logic [ADDR_W-1:0]      address_bus_o,
  output logic                   chip_sel_n_o,
  output logic                   write_n_o,
  output logic                   out_gate_n_o,
  input  wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0]      data_bus_o,
  output logic                   data_bus_oe_o
);
  localparam int TW = 24;
  initial begin
    if (STORE_WAIT < 1 || RECALL_WAIT < 1 || STORE_WAIT >= (1 << TW) ||
        RECALL_WAIT >= (1 << TW))
      $error("wait counts out of range");
  end

  typedef enum logic [5:0] {
    ST_PWRUP  = 6'h01,
    ST_IDLE   = 6'h02,
    ST_STROBE = 6'h04,
    ST_GAP    = 6'h08,
    ST_NVWAIT = 6'h10,
    ST_SEQ    = 6'h20
  } state_t;

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                 input logic is_store);
    case (idx)
      3'h0: seq_addr = SEQ_A0;
      3'h1: seq_addr = SEQ_A1;
      3'h2: seq_addr = SEQ_A2;
      3'h3: seq_addr = SEQ_A3;
      3'h4: seq_addr = SEQ_A4;
      default: seq_addr = is_store ? SEQ_STORE : SEQ_RECALL;
    endcase
  endfunction : seq_addr

  state_t            st_q, st_d;
  logic [1:0]        op_q, op_d;
  logic [2:0]        step_q, step_d;
  logic [7:0]        cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic              cs_q, cs_d, we_q, we_d, oe_q, oe_d, doe_q, doe_d;
  logic              rdy_q, rdy_d, rv_q, rv_d, nvb_q, nvb_d;
  logic              t_load, t_busy, t_done, pg_q;
  logic [TW-1:0]     t_val;

  nvsram_wait_timer #(.CNT_W(TW)) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (t_load),
    .value_i (t_val),
    .busy_o  (t_busy),
    .done_o  (t_done)
  );

  always_comb begin
    st_d = st_q; op_d = op_q; step_d = step_q; cnt_d = cnt_q;
    addr_d = addr_q; wd_d = wd_q; rd_d = rd_q;
    cs_d = cs_q; we_d = we_q; oe_d = oe_q; doe_d = doe_q;
    rdy_d = 1'b0; rv_d = 1'b0; nvb_d = nvb_q;
    t_load = 1'b0; t_val = '0;
    case (st_q)
      ST_PWRUP: begin
        // write held high so the power-up recall cannot corrupt data
        we_d = 1'b1; // see R17
        if (power_good_i && !pg_q) begin
          t_load = 1'b1;
          t_val = TW'(RECALL_WAIT); // see R15
          nvb_d = 1'b1;
          st_d = ST_NVWAIT;
        end
      end
      ST_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid_i && rdy_q) begin
          rdy_d = 1'b0;
          op_d = req_op_i;
          wd_d = req_wdata_i;
          step_d = '0;
          cnt_d = '0;
          if (req_op_i == OP_STORE && low_supply_i) begin
            rv_d = 1'b1; // see R16
          end else if (req_op_i == OP_READ || req_op_i == OP_WRITE) begin
            addr_d = req_addr_i; // see R20
            cs_d = 1'b0;
            we_d = (req_op_i != OP_WRITE); // see R18
            oe_d = (req_op_i != OP_READ); // see R21
            doe_d = (req_op_i == OP_WRITE);
            st_d = ST_STROBE;
          end else begin
            // each step is a separate read pulse, write kept high
            addr_d = SEQ_A0; // see R1
            cs_d = 1'b0; // see R7
            we_d = 1'b1; // see R4
            oe_d = 1'b1; // see R6
            nvb_d = 1'b1;
            st_d = ST_STROBE;
          end
        end
      end
      ST_STROBE: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q >= 8'(CS_PULSE_CYC - 1)) begin
          cs_d = 1'b1; // see R8
          we_d = 1'b1;
          oe_d = 1'b1;
          cnt_d = '0;
          if (op_q == OP_READ) rd_d = data_bus_i;
          st_d = ST_GAP;
        end
      end
      ST_GAP: begin
        doe_d = 1'b0;
        cnt_d = cnt_q + 8'h01;
        if (cnt_q >= 8'(CYCLE_CYC - CS_PULSE_CYC)) begin
          cnt_d = '0;
          if (op_q == OP_READ || op_q == OP_WRITE) begin
            rv_d = 1'b1;
            st_d = ST_IDLE;
          end else if (step_q == 3'(SEQ_LEN - 1)) begin
            // device is deaf now; nothing goes out until it is done
            t_load = 1'b1; // see R10
            t_val = TW'((op_q == OP_STORE) ? STORE_WAIT : RECALL_WAIT);
            st_d = ST_NVWAIT; // see R2 R3 R11
          end else begin
            step_d = step_q + 3'h1;
            st_d = ST_SEQ;
          end
        end
      end
      ST_SEQ: begin
        // distinct address each step so no repeat breaks it
        addr_d = seq_addr(step_q, op_q == OP_STORE); // see R9 R5 R22
        cs_d = 1'b0;
        st_d = ST_STROBE;
      end
      ST_NVWAIT: begin
        // erase/program and clear/copy run inside the device
        if (t_done) begin // see R12 R13 R14
          nvb_d = 1'b0;
          // power-up recall has no requester, so no response then
          if (op_q != OP_READ && op_q != OP_WRITE) rv_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_PWRUP;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_PWRUP; op_q <= OP_READ; step_q <= '0; cnt_q <= '0;
      addr_q <= '0; wd_q <= '0; rd_q <= '0; cs_q <= 1'b1; we_q <= 1'b1;
      oe_q <= 1'b1; doe_q <= 1'b0; rdy_q <= 1'b0; rv_q <= 1'b0;
      nvb_q <= 1'b0; pg_q <= 1'b0;
    end else begin
      st_q <= st_d; op_q <= op_d; step_q <= step_d; cnt_q <= cnt_d;
      addr_q <= addr_d; wd_q <= wd_d; rd_q <= rd_d; cs_q <= cs_d;
      we_q <= we_d; oe_q <= oe_d; doe_q <= doe_d; rdy_q <= rdy_d;
      rv_q <= rv_d; nvb_q <= nvb_d; pg_q <= power_good_i;
    end
  end

  assign req_ready_o = rdy_q;
  assign rsp_valid_o = rv_q;
  assign rsp_rdata_o = rd_q;
  assign nv_busy_o = nvb_q;
  assign address_bus_o = addr_q;
  assign chip_sel_n_o = cs_q;
  assign write_n_o = we_q;
  assign out_gate_n_o = oe_q;
  assign data_bus_o = wd_q;
  assign data_bus_oe_o = doe_q;

  AST_SEQ_WRITE_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    (nvb_q && !chip_sel_n_o) |-> write_n_o) // see R4
    else $error("write low in command");
  AST_NO_ACCESS_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ST_NVWAIT) |-> chip_sel_n_o) // see R11
    else $error("access while busy");
  AST_PULSE_WIDTH: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(chip_sel_n_o) |-> !chip_sel_n_o[*2]) // see R8
    else $error("select pulse short");
  AST_WRITE_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !write_n_o |-> out_gate_n_o && data_bus_oe_o) // see R21
    else $error("gate low in write");
  AST_READ_NO_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!out_gate_n_o) |-> !data_bus_oe_o && write_n_o) // see R18
    else $error("drive during read");
  AST_FIRST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    (nvb_q && $fell(chip_sel_n_o) && step_q == 3'h0 && st_q == ST_STROBE)
    |-> address_bus_o == SEQ_A0) // see R1
    else $error("bad first step");
  AST_ADDR_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!chip_sel_n_o && !$fell(chip_sel_n_o)) |-> $stable(address_bus_o))
    // see R20
    else $error("address moved");
  AST_NO_STORE_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    (rdy_q && req_valid_i && req_op_i == OP_STORE && low_supply_i)
    |=> chip_sel_n_o) // see R16
    else $error("store under low supply");
  AST_TIMER_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ST_NVWAIT && !t_done) |-> t_busy) // see R13
    else $error("wait timer idle while waiting");
  COV_STORE: cover property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_NVWAIT && op_q == OP_STORE);
  COV_RECALL: cover property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_NVWAIT && op_q == OP_RECALL);
  COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i)
    !write_n_o);
endmodule : nvsram_host_ctrl

// ### hdl/nvsram_wait_timer.sv
module nvsram_wait_timer
  import nvsram_host_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // start with a load value, done pulses when it runs out
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  output logic                  busy_o,
  output logic                  done_o
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             busy_q, busy_d, done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (load_i) begin
      cnt_d = value_i;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= CNT_W'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
endmodule : nvsram_wait_timer

// ### inc/nvsram_host_pkg.sv
package nvsram_host_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 25;
  localparam logic [ADDR_W-1:0] SEQ_A0 = 13'h0000;
  localparam logic [ADDR_W-1:0] SEQ_A1 = 13'h1555;
  localparam logic [ADDR_W-1:0] SEQ_A2 = 13'h0AAA;
  localparam logic [ADDR_W-1:0] SEQ_A3 = 13'h1FFF;
  localparam logic [ADDR_W-1:0] SEQ_A4 = 13'h10F0;
  localparam logic [ADDR_W-1:0] SEQ_STORE = 13'h0F0F;
  localparam logic [ADDR_W-1:0] SEQ_RECALL = 13'h0F0E;
  localparam int SEQ_LEN = 6;
  // strobe timing: least pulse and cycle times, rounded up to whole cycles
  localparam int CS_PULSE_NS = 45;
  localparam int CYCLE_NS = 55;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int CS_PULSE_CYC = (CS_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_DURATION_MS = 10;
  localparam int RECALL_DURATION_US = 20;
  localparam int STORE_CYC = STORE_DURATION_MS * 1000 * CLK_MHZ;
  localparam int RECALL_CYC = RECALL_DURATION_US * CLK_MHZ;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_STORE = 2'h2;
  localparam logic [1:0] OP_RECALL = 2'h3;
endpackage : nvsram_host_pkg

// ### verif/nv_sram_store_recall_control_tb.sv
module nv_sram_store_recall_control_tb
  import nvsram_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RECALL_WAIT = 20;
  logic              clk_i, rst_i, req_valid, req_ready, rsp_valid, nv_busy;
  logic              power_good, low_supply, cs_n, we_n, og_n, oe;
  logic [1:0]        req_op;
  logic [ADDR_W-1:0] req_addr, addr;
  logic [DATA_W-1:0] req_wdata, rdata, dq_in, dq_out, q;
  int                store_cnt, recall_cnt, viol_cnt;
  int                error_cnt, checked, cyc;
  nvsram_host_ctrl #(.STORE_WAIT(50), .RECALL_WAIT(RECALL_WAIT))
    i_nvsram_host_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .req_valid_i(req_valid), .req_op_i(req_op), .req_addr_i(req_addr),
    .req_wdata_i(req_wdata), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata), .nv_busy_o(nv_busy),
    .power_good_i(power_good), .low_supply_i(low_supply),
    .address_bus_o(addr), .chip_sel_n_o(cs_n), .write_n_o(we_n),
    .out_gate_n_o(og_n), .data_bus_i(dq_in), .data_bus_o(dq_out),
    .data_bus_oe_o(oe));
  nvsram_dev_model i_nvsram_dev_model (.address_bus_i(addr),
    .chip_sel_n_i(cs_n), .write_n_i(we_n), .out_gate_n_i(og_n),
    .data_bus_i(oe ? dq_out : ~dq_out), .data_bus_o(dq_in),
    .power_good_i(power_good), .low_supply_i(low_supply),
    .store_cnt_o(store_cnt), .recall_cnt_o(recall_cnt),
    .viol_cnt_o(viol_cnt));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // request raised and dropped on falling edges, answer read there too
  task automatic xfer(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clk_i);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    chk(n < 1000, 1);
    q = rdata;
  endtask : xfer
  task automatic t_powerup();
    int n;
    repeat (3) @(negedge clk_i);
    chk(req_ready, 0);
    power_good = 1'b1;
    repeat (5) @(negedge clk_i);
    chk(nv_busy, 1);
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chk(n + 5 >= RECALL_WAIT && n < 200, 1);
    chk(recall_cnt, 1);
  endtask : t_powerup
  task automatic t_rw();
    xfer(OP_WRITE, 13'h1234, 8'hA5);
    xfer(OP_READ, 13'h1234, 8'h00);
    chk(q, 8'hA5);
    xfer(OP_READ, 13'h0777, 8'h00);
    chk(q, 8'h5A);
  endtask : t_rw
  task automatic t_store_recall();
    xfer(OP_WRITE, 13'h0010, 8'h3C);
    xfer(OP_STORE, 13'h0000, 8'h00);
    chk(store_cnt, 1);
    xfer(OP_WRITE, 13'h0010, 8'h00);
    xfer(OP_RECALL, 13'h0000, 8'h00);
    chk(recall_cnt, 2);
    xfer(OP_READ, 13'h0010, 8'h00);
    chk(q, 8'h3C);
    xfer(OP_READ, 13'h1234, 8'h00);
    chk(q, 8'hA5);
  endtask : t_store_recall
  task automatic t_low_supply();
    low_supply = 1'b1;
    xfer(OP_STORE, 13'h0000, 8'h00);
    chk(store_cnt, 1);
    low_supply = 1'b0;
    xfer(OP_READ, 13'h0010, 8'h00);
    chk(q, 8'h3C);
  endtask : t_low_supply
  // ceiling is far above the few hundred cycles the scenarios need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    rst_i = 1'b1;
    req_valid = 1'b0;
    req_op = OP_READ;
    req_addr = '0;
    req_wdata = '0;
    power_good = 1'b0;
    low_supply = 1'b0;
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    t_powerup();
    t_rw();
    t_store_recall();
    t_low_supply();
    chk(viol_cnt, 0);
    tally_and_finish();
  end
endmodule : nv_sram_store_recall_control_tb

// ### verif/nvsram_dev_model.sv
module nvsram_dev_model
  import nvsram_host_pkg::*;
#(
  parameter int STORE_NS  = 1000,
  parameter int RECALL_NS = 400
) (
  // memory pins
  input  wire logic [ADDR_W-1:0] address_bus_i,
  input  wire logic              chip_sel_n_i,
  input  wire logic              write_n_i,
  input  wire logic              out_gate_n_i,
  input  wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0]      data_bus_o,
  // supply and status
  input  wire logic              power_good_i,
  input  wire logic              low_supply_i,
  output int                     store_cnt_o,
  output int                     recall_cnt_o,
  output int                     viol_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] nv  [2**ADDR_W];
  logic [ADDR_W-1:0] seq [5];
  logic [DATA_W-1:0] held;
  logic              busy;
  logic              drv;
  logic              wr_on;
  realtime           wr_t0;
  int                step;
  // sram stays off until the power-up recall has run
  initial begin
    seq = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    foreach (nv[i]) nv[i] = 8'h5A;
    busy = 1'b1;
    step = 0;
    held = 8'h00;
    wr_on = 1'b0;
    wr_t0 = 0.0;
    store_cnt_o = 0;
    recall_cnt_o = 0;
    viol_cnt_o = 0;
  end
  task automatic do_recall();
    busy = 1'b1;
    recall_cnt_o++;
    foreach (mem[i]) mem[i] = 8'h00;
    #(RECALL_NS);
    foreach (mem[i]) mem[i] = nv[i];
    busy = 1'b0;
  endtask : do_recall
  task automatic do_store();
    busy = 1'b1;
    store_cnt_o++;
    foreach (nv[i]) nv[i] = 8'hFF;
    for (int t = 0; t < STORE_NS && !low_supply_i; t++) #1;
    if (!low_supply_i) foreach (nv[i]) nv[i] = mem[i];
    busy = 1'b0;
  endtask : do_store
  always @(posedge power_good_i) do_recall();
  // output gate is not looked at here; inputs ignored while busy
  always @(negedge chip_sel_n_i) begin
    // let strobes that move in the same step settle before decoding
    #1;
    if (!busy) begin
      if (!write_n_i) step = 0;
      else if (step == 5 && address_bus_i == SEQ_STORE) begin
        step = 0;
        if (!low_supply_i) do_store();
      end else if (step == 5 && address_bus_i == SEQ_RECALL) begin
        step = 0;
        do_recall();
      end else if (step < 5 && address_bus_i == seq[step]) step++;
      else step = (address_bus_i == SEQ_A0) ? 1 : 0;
    end
  end
  // both strobes may rise together, so the write is tracked as a level
  always @(chip_sel_n_i or write_n_i) begin
    if (!chip_sel_n_i && !write_n_i) begin
      if (!wr_on && !busy) begin
        wr_on = 1'b1;
        wr_t0 = $realtime;
      end
    end else if (wr_on) begin
      wr_on = 1'b0;
      mem[address_bus_i] = data_bus_i;
    end
  end
  assign drv = !chip_sel_n_i && !out_gate_n_i && write_n_i && !busy;
  always @(drv or address_bus_i) if (drv) held = mem[address_bus_i];
  // undriven bus shows the inverse of the last byte, never a stale match
  assign data_bus_o = drv ? mem[address_bus_i] : ~held;
  always @(negedge write_n_i)
    if (!out_gate_n_i || !power_good_i || busy) viol_cnt_o++;
  // an address set in the same step as the write opens is legal
  always @(address_bus_i)
    if (wr_on && $realtime > wr_t0) viol_cnt_o++;
endmodule : nvsram_dev_model
